// File: design/bdc_pkg.sv
// Purpose: shared constants for the burst dimming and clock configuration block
// Assumes: one 250 MHz system clock, synchronous active-high reset
// Notes:   register offsets are byte indices on the configuration port
package bdc_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO   = 8'h01;
  localparam logic [7:0] OFS_BURST_CODE = 8'h02;
  localparam logic [7:0] OFS_ANALOG_BRIGHTNESS_INPUT_CUR = 8'h03;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_DIM_SRC       = 0;
  localparam int BIT_DIM_CLK_SRC   = 1;
  localparam int BIT_BURST_OUT_SEL = 2;
  localparam int BIT_LAMP_CLK_SRC  = 3;
  localparam int BIT_RANGE_LO      = 0;
  localparam int BIT_RANGE_HI      = 1;
  localparam int BIT_SHADOW_INH    = 7;
  // ---------------------------------------------------------------
  // reset values and figures
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_CTRL_ONE   = 8'h00;
  localparam logic [7:0] RST_CTRL_TWO   = 8'h00;
  localparam logic [6:0] RST_BURST_CODE = 7'h00;
  localparam logic [4:0] RST_LAMP_CUR   = 5'h00;
  localparam logic [6:0] BURST_FULL     = 7'h7f;
  localparam int         BURST_STEPS    = 128;
  localparam int         NVM_WRITE_NS   = 10000;
  localparam int         CLK_PERIOD_NS  = 4;
  localparam int         NVM_WRITE_CYC  = (NVM_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         NUM_LOC        = 4;
endpackage : bdc_pkg

// File: design/bdc_cfg_if.sv
// Purpose: carrier between the controller and its burst pwm generator
// Assumes: single clock domain
// Notes:   none
`timescale 1ns/1ns
interface bdc_cfg_if;
  logic       dim_tick;
  logic [6:0] duty_code;
  logic       pwm;
  modport ctrl (output dim_tick, output duty_code, input pwm);
  modport gen  (input dim_tick, input duty_code, output pwm);
endinterface : bdc_cfg_if

// File: design/bdc_pwm_gen.sv
// Purpose: internal burst pwm generator, one burst period per dimming clock period
// Assumes: dim_tick pulses once per dimming clock period
// Notes:   high time is code slices of SLICE_CYC cycles, code 127 holds it high; the slice count stops at 127 until the next dim_tick
`timescale 1ns/1ns
module bdc_pwm_gen #(
  parameter int SLICE_CYC = 4096
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  bdc_cfg_if.gen    cfg
);
  // ---------------------------------------------------------------
  // slice timing and duty compare
  // ---------------------------------------------------------------
  logic [6:0]  slice;
  logic [6:0]  code_lat;
  logic [31:0] slice_cnt;
  wire         slice_end = (slice_cnt == 32'(SLICE_CYC - 1));
  wire         next_pwm  = (code_lat == bdc_pkg::BURST_FULL) || (slice < code_lat);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || cfg.dim_tick)
    begin
      slice_cnt <= '0;
      slice     <= '0;
      code_lat  <= rst_i ? bdc_pkg::RST_BURST_CODE : cfg.duty_code;
    end
    else if (slice_end)
    begin
      slice_cnt <= '0;
      slice     <= (slice == 7'h7f) ? slice : slice + 7'h01;
    end
    else
      slice_cnt <= slice_cnt + 32'h0000_0001;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      cfg.pwm <= 1'b0;
    else
      cfg.pwm <= next_pwm;
  end

  full_on_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (code_lat == bdc_pkg::BURST_FULL) |=> cfg.pwm)
    else $error("full code did not hold pwm high");
  update_boundary_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !cfg.dim_tick |=> $stable(code_lat))
    else $error("duty code changed mid period");
endmodule // bdc_pwm_gen

// File: design/bdc_top.sv
// Purpose: burst dimming, dimming/lamp clock selection, lamp current code, shadow write control
// Assumes: register port is a byte-wide strobed write/read port behind the serial slave
// Notes:   clock pins are sampled as synchronous levels; edges are detected here
`timescale 1ns/1ns
// Functional notes
// - shadow write inhibit bit reads zero after power-up, writes go to storage.
// - with inhibit set, writes touch only volatile cells, no storage write delay.
// - after power-up only the two control registers reload from storage; burst code and lamp current keep theirs.
// - lamp gate pulses of the two channels are in antiphase during burst.
// - burst dimming gives 128 linearly spaced duty steps.
// - gates toggle at lamp rate while burst high, disabled while low.
// - dimming clock source select picks external pin at 1, internal oscillator at 0.
// - receiver takes burst from shared pin, ignores brightness input and dim pin.
// - analog brightness maps below 0.5V to minimum, above 2.0V to full, linear.
// - a non-zero burst code write hands duty control to the serial port.
// - burst code 1 gives minimum duty, 127 gives full duty, linear between.
// - lamp current code comes only from the low five bits of the register.
// - lamp current code resets to zero meaning full current, 31 means 35%.
// - an internal lamp clock is driven out on the shared lamp clock pin.
// - the lamp clock driven out stays unmodulated by spread or step features.
module bdc_top #(
  parameter int SLICE_CYC     = 4096,
  parameter int NVM_WRITE_CYC = bdc_pkg::NVM_WRITE_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_busy_o,
  input  wire logic [7:0] nvm_image_i,
  input  wire logic [7:0] nvm_image_hi_i,
  input  wire logic       nvm_load_i,
  output logic            nvm_wr_o,
  output logic      [7:0] nvm_addr_o,
  output logic      [7:0] nvm_wdata_o,
  input  wire logic [6:0] analog_brightness_input_i,
  input  wire logic       dim_osc_int_i,
  input  wire logic       dimming_oscillator_pin_i,
  input  wire logic       lamp_osc_int_i,
  input  wire logic       lamp_osc_mod_i,
  input  wire logic       shared_burst_pin_i,
  output logic            shared_burst_pin_o,
  output logic            shared_burst_pin_oe_o,
  input  wire logic       shared_lamp_clock_pin_i,
  output logic            shared_lamp_clock_pin_o,
  output logic            shared_lamp_clock_pin_oe_o,
  input  wire logic       spread_enable_i,
  output logic            burst_pwm_signal_o,
  output logic      [1:0] gate_ch0_o,
  output logic      [1:0] gate_ch1_o,
  output logic      [4:0] lamp_current_code_o,
  output logic      [1:0] dim_clock_range_o
);
  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] control_reg_one;
  logic [7:0] control_reg_two;
  logic [6:0] burst_code_register;
  logic [7:0] brightness_current_ctrl;
  logic       serial_duty;
  logic [31:0] nvm_cnt;

  wire shadow_write_inhibit     = brightness_current_ctrl[bdc_pkg::BIT_SHADOW_INH];
  wire dimming_source_select    = control_reg_one[bdc_pkg::BIT_DIM_SRC];
  wire dim_clock_source_select  = control_reg_one[bdc_pkg::BIT_DIM_CLK_SRC];
  wire burst_output_select      = control_reg_one[bdc_pkg::BIT_BURST_OUT_SEL];
  wire lamp_clock_source_select = control_reg_one[bdc_pkg::BIT_LAMP_CLK_SRC];
  wire dim_clock_range_lo       = control_reg_two[bdc_pkg::BIT_RANGE_LO];
  wire dim_clock_range_hi       = control_reg_two[bdc_pkg::BIT_RANGE_HI];

  wire wr_ok     = reg_wr_i && !reg_busy_o;
  wire wr_one    = wr_ok && (reg_addr_i == bdc_pkg::OFS_CTRL_ONE);
  wire wr_two    = wr_ok && (reg_addr_i == bdc_pkg::OFS_CTRL_TWO);
  wire wr_code   = wr_ok && (reg_addr_i == bdc_pkg::OFS_BURST_CODE);
  wire wr_analog_brightness_input = wr_ok && (reg_addr_i == bdc_pkg::OFS_ANALOG_BRIGHTNESS_INPUT_CUR);
  wire wr_mapped = wr_one || wr_two || wr_code || wr_analog_brightness_input;
  // the inhibit bit itself is volatile; the others are shadowed
  wire wr_commit = wr_mapped && !shadow_write_inhibit;
  wire [7:0] commit_data = wr_analog_brightness_input ? {1'b0, reg_wdata_i[6:0]} : reg_wdata_i;

  wire [7:0] rd_mux =
    (reg_addr_i == bdc_pkg::OFS_CTRL_ONE)   ? control_reg_one :
    (reg_addr_i == bdc_pkg::OFS_CTRL_TWO)   ? control_reg_two :
    (reg_addr_i == bdc_pkg::OFS_BURST_CODE) ? {1'b0, burst_code_register} :
    (reg_addr_i == bdc_pkg::OFS_ANALOG_BRIGHTNESS_INPUT_CUR) ? brightness_current_ctrl : 8'h00;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      control_reg_one         <= bdc_pkg::RST_CTRL_ONE;
      control_reg_two         <= bdc_pkg::RST_CTRL_TWO;
      burst_code_register     <= bdc_pkg::RST_BURST_CODE;
      brightness_current_ctrl <= {3'h0, bdc_pkg::RST_LAMP_CUR};
      serial_duty             <= 1'b0;
    end
    else if (nvm_load_i)
    begin
      // stored image reappears at power-up, inhibit is forced clear
      control_reg_one         <= nvm_image_i;
      control_reg_two         <= nvm_image_hi_i;
      brightness_current_ctrl <= {1'b0, brightness_current_ctrl[6:0]};
    end
    else
    begin
      if (wr_one)
        control_reg_one <= reg_wdata_i;
      if (wr_two)
        control_reg_two <= reg_wdata_i;
      if (wr_code)
      begin
        burst_code_register <= reg_wdata_i[6:0];
        if (reg_wdata_i[6:0] != 7'h00)
          serial_duty <= 1'b1;
      end
      if (wr_analog_brightness_input)
        brightness_current_ctrl <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o <= 8'h00;
      nvm_wr_o    <= 1'b0;
      nvm_addr_o  <= 8'h00;
      nvm_wdata_o <= 8'h00;
      reg_busy_o  <= 1'b0;
      nvm_cnt     <= '0;
    end
    else
    begin
      if (reg_rd_i)
        reg_rdata_o <= rd_mux;
      nvm_wr_o <= wr_commit;
      if (wr_commit)
      begin
        nvm_addr_o  <= reg_addr_i;
        nvm_wdata_o <= commit_data;
        nvm_cnt     <= 32'(NVM_WRITE_CYC);
        reg_busy_o  <= 1'b1;
      end
      else if (nvm_cnt > 32'h0000_0001)
        nvm_cnt <= nvm_cnt - 32'h0000_0001;
      else
      begin
        nvm_cnt    <= '0;
        reg_busy_o <= 1'b0;
      end
    end
  end

  no_nvm_inhibit_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (wr_mapped && shadow_write_inhibit) |=> (!nvm_wr_o && !reg_busy_o))
    else $error("storage write while inhibited");
  reset_inhibit_a: assert property (@(posedge clk_sys_i)
    ($past(rst_i) && !rst_i) |-> !shadow_write_inhibit)
    else $error("inhibit bit set after reset");

  // ---------------------------------------------------------------
  // dimming clock and burst pwm selection
  // ---------------------------------------------------------------
  logic dim_clk_q;
  logic lamp_q;
  logic lamp_ref_q;
  logic lamp_phase;
  wire  dim_clk_sel  = dim_clock_source_select ? dimming_oscillator_pin_i : dim_osc_int_i;
  wire  dim_tick     = dim_clk_sel && !dim_clk_q;
  wire  receiver     = dimming_source_select;
  // brightness input arrives already quantised: 0 below 0.5V, 127 above 2.0V
  wire [6:0] analog_brightness_input_code = (analog_brightness_input_i == 7'h00) ? 7'h01 : analog_brightness_input_i;
  wire [6:0] duty_sel    = serial_duty ? burst_code_register : analog_brightness_input_code;
  bdc_cfg_if cfg_bus ();
  assign cfg_bus.dim_tick  = dim_tick && !receiver;
  assign cfg_bus.duty_code = duty_sel;
  bdc_pwm_gen #(
    .SLICE_CYC (SLICE_CYC)
  ) u_pwm (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .cfg       (cfg_bus.gen)
  );
  wire burst_now = receiver ? shared_burst_pin_i : cfg_bus.pwm;

  // ---------------------------------------------------------------
  // lamp clock and gate drive
  // ---------------------------------------------------------------
  wire lamp_ref = lamp_clock_source_select ? shared_lamp_clock_pin_i : lamp_osc_int_i;
  wire lamp_own = (spread_enable_i && !lamp_clock_source_select) ? lamp_osc_mod_i : lamp_ref;
  wire lamp_rise = lamp_own && !lamp_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      dim_clk_q                  <= 1'b0;
      lamp_q                     <= 1'b0;
      lamp_ref_q                 <= 1'b0;
      lamp_phase                 <= 1'b0;
      burst_pwm_signal_o         <= 1'b0;
      gate_ch0_o                 <= 2'h0;
      gate_ch1_o                 <= 2'h0;
      shared_burst_pin_o         <= 1'b0;
      shared_burst_pin_oe_o      <= 1'b0;
      shared_lamp_clock_pin_o    <= 1'b0;
      shared_lamp_clock_pin_oe_o <= 1'b0;
      lamp_current_code_o        <= bdc_pkg::RST_LAMP_CUR;
      dim_clock_range_o          <= 2'h0;
    end
    else
    begin
      dim_clk_q          <= dim_clk_sel;
      lamp_q             <= lamp_own;
      lamp_ref_q         <= lamp_osc_int_i;
      burst_pwm_signal_o <= burst_now;
      if (lamp_rise)
        lamp_phase <= !lamp_phase;
      // channels alternate gate pairs; both off outside the burst
      gate_ch0_o <= burst_now ? (lamp_phase ? 2'b10 : 2'b01) : 2'b00;
      gate_ch1_o <= burst_now ? (lamp_phase ? 2'b01 : 2'b10) : 2'b00;
      shared_burst_pin_o    <= cfg_bus.pwm;
      shared_burst_pin_oe_o <= !receiver && !burst_output_select;
      shared_lamp_clock_pin_o    <= lamp_ref_q;
      shared_lamp_clock_pin_oe_o <= !lamp_clock_source_select;
      lamp_current_code_o <= brightness_current_ctrl[4:0];
      dim_clock_range_o   <= {dim_clock_range_hi, dim_clock_range_lo};
    end
  end

  antiphase_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (gate_ch0_o != 2'b00) |-> (gate_ch1_o == ~gate_ch0_o))
    else $error("channels not in antiphase");
  gate_off_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !burst_pwm_signal_o |-> (gate_ch0_o == 2'b00 && gate_ch1_o == 2'b00))
    else $error("gates driven outside burst");
  lamp_out_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !lamp_clock_source_select |=> shared_lamp_clock_pin_oe_o)
    else $error("lamp clock not driven out");
  recv_ignore_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    receiver |=> burst_pwm_signal_o == $past(shared_burst_pin_i))
    else $error("receiver not following shared pin");
  burst_drive_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    receiver |=> !shared_burst_pin_oe_o)
    else $error("receiver driving burst pin");
endmodule // bdc_top

// File: tb/bdc_peer_model.sv
// Purpose: companion controller on the shared burst and lamp clock pins
// Assumes: drives only when enabled and the block has released the pin
// Notes:   an undriven wire toggles each cycle so a stale value never passes
`timescale 1ns/1ns
module bdc_peer_model (
  input  wire logic clk_sys_i,
  input  wire logic drive_i,
  input  wire logic burst_level_i,
  input  wire logic burst_o_i,
  input  wire logic burst_oe_i,
  input  wire logic lamp_o_i,
  input  wire logic lamp_oe_i,
  output logic      burst_wire_o,
  output logic      lamp_wire_o
);
  logic       float_q = 1'b0;
  logic [3:0] lamp_div = 4'h0;
  always @(posedge clk_sys_i)
  begin
    float_q <= ~float_q;
    lamp_div <= lamp_div + 4'h1;
  end
  // companion as burst source, the block as receiver
  assign burst_wire_o = burst_oe_i ? burst_o_i : (drive_i ? burst_level_i : float_q);
  // companion as lamp clock source for a receiving block
  assign lamp_wire_o = lamp_oe_i ? lamp_o_i : (drive_i ? lamp_div[3] : float_q);
endmodule // bdc_peer_model

// File: tb/tb.sv
// Purpose: register sequences and pin checks for the burst dimming block
// Assumes: short storage write and slice counts for simulation
// Notes:   all inputs change by non-blocking assignment, on the rising edge or 1 ns after it
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic clk_sys_i = 0, rst_i = 1, wr = 0, rd = 0, ld = 0, drv = 0, pl = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata, naddr, nwdata;
  logic [6:0] analog_brightness_input = 7'h00;
  logic dosc = 0, dpin = 0, lamp_oscillator_pin = 0, lmod = 0, spread = 0;
  logic bw, lw, bo, boe, lo, loe, busy, nwr, pwm;
  logic [1:0] g0, g1, rng;
  logic [4:0] lcc;
  int err_total = 0, checks_done = 0, cyc = 0, hi, act;
  // lamp clock out is two flops behind the internal oscillator
  logic [1:0] lamp_oscillator_pin_d = 2'b00;
  initial forever #2 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    // internal dimming period matches 128 slices of 2 cycles; the pin clock is 4x slower
    if (cyc % 128 == 127) dosc <= ~dosc;
    if (cyc % 512 == 511) dpin <= ~dpin;
    lamp_oscillator_pin_d <= {lamp_oscillator_pin_d[0], lamp_oscillator_pin};
    if (cyc % 5 == 4) lamp_oscillator_pin <= ~lamp_oscillator_pin;
    if (cyc % 3 == 2) lmod <= ~lmod;
    if (cyc == 60000) begin err_total++; conclude(); end
  end
  bdc_top #(.SLICE_CYC(2), .NVM_WRITE_CYC(4)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata),
    .reg_busy_o(busy), .nvm_image_i(8'h00), .nvm_image_hi_i(8'h02), .nvm_load_i(ld),
    .nvm_wr_o(nwr), .nvm_addr_o(naddr), .nvm_wdata_o(nwdata), .analog_brightness_input_i(analog_brightness_input),
    .dim_osc_int_i(dosc), .dimming_oscillator_pin_i(dpin), .lamp_osc_int_i(lamp_oscillator_pin),
    .lamp_osc_mod_i(lmod), .shared_burst_pin_i(bw), .shared_burst_pin_o(bo),
    .shared_burst_pin_oe_o(boe), .shared_lamp_clock_pin_i(lw), .shared_lamp_clock_pin_o(lo),
    .shared_lamp_clock_pin_oe_o(loe), .spread_enable_i(spread), .burst_pwm_signal_o(pwm),
    .gate_ch0_o(g0), .gate_ch1_o(g1), .lamp_current_code_o(lcc), .dim_clock_range_o(rng));
  bdc_peer_model peer (.clk_sys_i(clk_sys_i), .drive_i(drv), .burst_level_i(pl), .burst_o_i(bo),
    .burst_oe_i(boe), .lamp_o_i(lo), .lamp_oe_i(loe), .burst_wire_o(bw), .lamp_wire_o(lw));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 100) begin @(posedge clk_sys_i); n++; end
    if (n == 100) err_total++;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] exp_wb);
    wait_idle();
    @(posedge clk_sys_i);
    wr <= 1; addr <= a; wd <= d;
    @(posedge clk_sys_i);
    wr <= 0;
    #1 check({nwr, busy}, exp_wb);
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    rd <= 1; addr <= a;
    @(posedge clk_sys_i);
    rd <= 0;
    @(posedge clk_sys_i);
    #1 check(rdata, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  // counts burst high cycles; gates must rest while burst is low
  task automatic measure();
    // let a dimming period boundary pass so the new code is latched
    settle(300);
    hi = 0; act = 0;
    repeat (1200)
    begin
      @(posedge clk_sys_i);
      #1;
      if (pwm === 1'b1) hi++;
      if (pwm === 1'b1 && g0 !== 2'b00) act++;
      if (pwm === 1'b0 && (g0 !== 2'b00 || g1 !== 2'b00)) check({g0, g1}, 8'h00);
      if (g0 !== 2'b00 && g0 === g1) check({g0, g1}, {g0, ~g0});
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 0;
    settle(1);
    reg_read(bdc_pkg::OFS_ANALOG_BRIGHTNESS_INPUT_CUR, 8'h00);
    check(lcc, 8'h00);
    reg_read(8'h07, 8'h00);
    @(posedge clk_sys_i) ld <= 1;
    @(posedge clk_sys_i) ld <= 0;
    reg_read(bdc_pkg::OFS_CTRL_TWO, 8'h02);
    check(rng, 8'h02);
    reg_write(bdc_pkg::OFS_ANALOG_BRIGHTNESS_INPUT_CUR, 8'h05, 2'b11);
    check({naddr[1:0], nwdata[5:0]}, {2'b11, 6'h05});
    settle(1);
    check(lcc, 8'h05);
    reg_write(bdc_pkg::OFS_ANALOG_BRIGHTNESS_INPUT_CUR, 8'h85, 2'b11);
    check(nwdata, 8'h05);
    reg_write(bdc_pkg::OFS_ANALOG_BRIGHTNESS_INPUT_CUR, 8'h9f, 2'b00);
    settle(1);
    check(lcc, 8'h1f);
    reg_read(bdc_pkg::OFS_ANALOG_BRIGHTNESS_INPUT_CUR, 8'h9f);
    reg_write(bdc_pkg::OFS_CTRL_TWO, 8'h01, 2'b00);
    settle(2);
    check(rng, 8'h01);
    analog_brightness_input <= 7'h7f;
    measure();
    check(hi == 1200, 1);
    check(act > 0, 1);
    check({boe, bo}, 8'h03);
    analog_brightness_input <= 7'h00;
    measure();
    check(hi > 4 && hi < 16, 1);
    reg_write(bdc_pkg::OFS_BURST_CODE, 8'h7f, 2'b00);
    measure();
    check(hi == 1200, 1);
    reg_write(bdc_pkg::OFS_BURST_CODE, 8'h40, 2'b00);
    measure();
    check(hi > 480 && hi < 720, 1);
    reg_write(bdc_pkg::OFS_BURST_CODE, 8'h00, 2'b00);
    measure();
    check(hi == 0, 1);
    reg_write(bdc_pkg::OFS_CTRL_ONE, 8'h02, 2'b00);
    reg_write(bdc_pkg::OFS_BURST_CODE, 8'h40, 2'b00);
    measure();
    // burst code 64 on the slow pin clock gives one or two 128-cycle bursts per window
    check(hi >= 100 && hi <= 260, 1);
    drv <= 1; pl <= 1; analog_brightness_input <= 7'h7f; spread <= 1;
    reg_write(bdc_pkg::OFS_CTRL_ONE, 8'h01, 2'b00);
    settle(4);
    check({boe, pwm}, 8'h01);
    @(posedge clk_sys_i) pl <= 0;
    settle(6);
    check({boe, pwm}, 8'h00);
    check(loe, 1);
    repeat (20) begin settle(1); check(lo, lamp_oscillator_pin_d[1]); end
    reg_write(bdc_pkg::OFS_CTRL_ONE, 8'h09, 2'b00);
    settle(4);
    check(loe, 0);
    conclude();
  end
endmodule // tb
